// [design/ducom_defines.svh]
// Purpose: shared constants for the dual serial unit with counter/timer
// Assumes: 100 MHz clk; the 3.6864 MHz rate reference arrives as a pin
// Notes: rate divisor is 6 << select, so select 0 gives 38400 baud at 16x
// How it works
// RQ1 - two independent full-duplex serial channels
// RQ2 - five to eight data bits per character
// RQ3 - even, odd or no parity, generated and checked
// RQ4 - stop interval in sixteenths, up to two bits
// RQ5 - four-deep receive, two-deep transmit buffers
// RQ6 - errors flagged, interrupt sources individually masked
// RQ7 - normal, echo, local and remote loop modes
// RQ8 - multidrop marks address versus data characters
// RQ9 - rate generator offers standard rates to 38400
// RQ10 - rates derived from separate 3.6864 MHz reference
// RQ11 - separate receive and transmit rate per channel
// RQ12 - per-channel request-to-send and clear-to-send lines
// RQ13 - sixteen-bit counter/timer, counter or timer mode
// RQ14 - counter mode: stopwatch, one-shot, watchdog
// RQ15 - timer mode: baud source, periodic, square wave
// RQ16 - low start, lsb first, parity, high stop
// RQ17 - 16x sampling, start checked at midpoint
// RQ18 - reset disables channels, empties buffers, stops timer
`ifndef DUCOM_DEFINES_SVH
`define DUCOM_DEFINES_SVH
`define DUCOM_MARK 1'b1
`define DUCOM_OVS 4'hF
`define DUCOM_MID 4'h7
`define DUCOM_PRE_LAST 3'h5
`define DUCOM_RX_DEPTH 3'h4
`define DUCOM_TX_DEPTH 2'h2
`define DUCOM_TMR_RST 16'h0000
`endif

// [design/ducom_pkg.sv]
// Purpose: types shared by the serial unit and its counter/timer
// Assumes: constants live in ducom_defines.svh
// Notes: one-hot state codes, one enum per state machine
`default_nettype none
package ducom_pkg;
  typedef enum logic [1:0] {
    mode_normal = 2'h0, mode_echo = 2'h1, mode_local = 2'h2, mode_remote = 2'h3
  } ducom_mode_t;
  typedef enum logic [4:0] {
    tx_idle = 5'b00001, tx_start = 5'b00010, tx_data = 5'b00100,
    tx_par = 5'b01000, tx_stop = 5'b10000
  } ducom_txs_t;
  typedef enum logic [4:0] {
    rx_idle = 5'b00001, rx_start = 5'b00010, rx_data = 5'b00100,
    rx_par = 5'b01000, rx_stop = 5'b10000
  } ducom_rxs_t;
  // per-channel configuration, held by software
  typedef struct packed {
    logic rx_en;
    logic tx_en;
    logic [1:0] bits_sel;   // 0..3 gives 5..8 data bits
    logic par_en;
    logic par_odd;
    logic [4:0] stop16;     // stop length in sixteenths minus one
    ducom_mode_t mode;
    logic multidrop;
    logic tx_addr;          // multidrop: next characters are addresses
    logic [3:0] rx_rate;    // bit 3 picks the timer, else 6 << [2:0]
    logic [3:0] tx_rate;
    logic cts_en;
    logic rts_on;
    logic [2:0] irq_mask;   // rx available, tx empty, error
  } ducom_cfg_t;
  typedef struct packed {
    logic frame_err;
    logic par_flag;         // parity error, or address mark in multidrop
    logic [7:0] data;
  } ducom_rx_t;
  typedef struct packed {
    logic timer_mode;       // 1 timer, 0 counter
    logic irq_en;
    logic [15:0] preload;
    logic [15:0] duty;
  } ducom_tmr_cfg_t;
  typedef struct packed {
    logic run;
    logic [15:0] cnt;
    logic wave;
    logic flag;
  } ducom_tmr_st_t;
  typedef struct packed {
    ducom_rx_t [3:0] rx_mem;
    logic [1:0] rx_rd;
    logic [2:0] rx_cnt;
    logic [1:0][7:0] tx_mem;
    logic tx_rd;
    logic [1:0] tx_cnt;
    ducom_txs_t tx_st;
    logic [4:0] tx_sub;
    logic [2:0] tx_bit;
    logic [7:0] tx_sh;
    logic tx_pbit;
    logic tx_line;
    ducom_rxs_t rx_st;
    logic [3:0] rx_sub;
    logic [2:0] rx_bit;
    logic [7:0] rx_sh;
    logic rx_par;
    logic rx_pbit;
    logic [2:0] rxd_sync;
    logic rxd_lvl;
    logic [2:0] cts_sync;
    logic cts_lvl;
    logic rx_on;
    logic tx_on;
    logic err;
    logic txd;
    logic rts_n;
  } ducom_ch_t;
  typedef struct packed {
    logic [2:0] ref_sync;
    logic ref_lvl;
    logic [2:0] pre;
    logic [6:0] div;
    ducom_ch_t [1:0] ch;
    logic irq;
  } ducom_st_t;
endpackage : ducom_pkg
`default_nettype wire

// [design/ducom_timer.sv]
// Purpose: sixteen-bit counter/timer clocked by reference-pin edges
// Assumes: tick is a one-cycle pulse per reference rising edge
// Notes: start also reloads, which is how a watchdog is kicked
`include "ducom_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ducom_timer (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic tick,
  input wire ducom_pkg::ducom_tmr_cfg_t cfg,
  input wire logic start,
  input wire logic stop,
  input wire logic ack,
  output logic [15:0] count,
  output logic wave,
  output logic flag,
  output logic baud_tick
);
  ducom_pkg::ducom_tmr_st_t s_reg;
  ducom_pkg::ducom_tmr_st_t s_next;
  logic hit;

  // count down on reference edges; zero raises the sticky flag
  always_comb begin
    s_next = s_reg;
    hit = 1'b0;
    if (start) begin
      s_next.run = 1'b1;                       // [RQ13] [RQ14]
      s_next.cnt = cfg.preload;
    end else if (stop) begin
      s_next.run = 1'b0;
    end else if (s_reg.run && tick) begin
      hit = (s_reg.cnt == 16'h0000);
      if (hit && cfg.timer_mode) begin
        s_next.cnt = cfg.preload;              // periodic reload [RQ15]
      end else begin
        s_next.cnt = s_reg.cnt - 16'h0001;     // counter wraps, stopwatch [RQ14]
      end
    end
    // duty set by compare, so period and duty are independent
    s_next.wave = cfg.timer_mode && s_next.run && (s_next.cnt < cfg.duty); // [RQ15]
    if (ack) begin
      s_next.flag = 1'b0;
    end
    if (hit) begin
      s_next.flag = 1'b1;                      // set beats ack [RQ14]
    end
  end

  // stopped and cleared at reset [RQ18]
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{cnt: `DUCOM_TMR_RST, default: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  assign count = s_reg.cnt;
  assign wave = s_reg.wave;
  assign flag = s_reg.flag;
  assign baud_tick = hit && cfg.timer_mode;    // 16x clock source [RQ15]
endmodule : ducom_timer
`default_nettype wire

// [design/ducom_top.sv]
// Purpose: two-channel asynchronous serial unit with counter/timer
// Assumes: config arrives as plain ports; pins are asynchronous to clk
// Notes: rate reference, rxd and cts_n pass three-stage synchronisers
`include "ducom_defines.svh"
`timescale 1ns/1ps
`default_nettype none
module ducom_top (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic ce,
  input wire logic ref_clk,
  input wire logic [1:0] rxd,
  output logic [1:0] txd,
  input wire logic [1:0] cts_n,
  output logic [1:0] rts_n,
  input wire ducom_pkg::ducom_cfg_t [1:0] ch_cfg,
  input wire logic [1:0][7:0] tx_data,
  input wire logic [1:0] tx_valid,
  output logic [1:0] tx_ready,
  output ducom_pkg::ducom_rx_t [1:0] rx_word,
  output logic [1:0] rx_valid,
  input wire logic [1:0] rx_pop,
  input wire logic [1:0] err_clr,
  output logic [1:0] ch_err,
  input wire ducom_pkg::ducom_tmr_cfg_t tmr_cfg,
  input wire logic tmr_start,
  input wire logic tmr_stop,
  input wire logic tmr_ack,
  output logic [15:0] tmr_count,
  output logic tmr_wave,
  output logic tmr_flag,
  output logic irq
);
  localparam ducom_pkg::ducom_ch_t CH_RST = '{
    tx_st: ducom_pkg::tx_idle, rx_st: ducom_pkg::rx_idle,
    tx_line: `DUCOM_MARK, txd: `DUCOM_MARK, rts_n: `DUCOM_MARK,
    rxd_lvl: `DUCOM_MARK, cts_lvl: `DUCOM_MARK,
    rxd_sync: {3{`DUCOM_MARK}}, cts_sync: {3{`DUCOM_MARK}}, default: '0};

  ducom_pkg::ducom_st_t s_reg;
  ducom_pkg::ducom_st_t s_next;
  ducom_pkg::ducom_ch_t c;
  ducom_pkg::ducom_ch_t n;
  ducom_pkg::ducom_cfg_t cf;
  ducom_pkg::ducom_rx_t word;
  logic ref_rise;
  logic base_tick;
  logic tmr_tick;
  logic rt;
  logic tt;
  logic has_p;
  logic line_in;
  logic tx_push;
  logic tx_pop;
  logic rx_push;
  logic rx_take;
  logic irq_any;
  logic [2:0] last;
  logic [7:0] dmask;

  // 16x tick for a rate select: timer output or 6 << sel reference edges
  function automatic logic rate_tick(input logic [3:0] r, input logic b,
                                     input logic [6:0] d, input logic tb);
    logic [6:0] m;
    m = 7'h7F >> (3'h7 - r[2:0]);
    rate_tick = r[3] ? tb : (b && ((d & m) == m));
  endfunction : rate_tick

  // reference edge counts only once stages two and three agree
  assign ref_rise = (s_reg.ref_sync[2] == s_reg.ref_sync[1]) &&
                    s_reg.ref_sync[1] && !s_reg.ref_lvl;        // [RQ10]
  assign base_tick = ref_rise && (s_reg.pre == `DUCOM_PRE_LAST); // 38400 x 16 [RQ9]

  ducom_timer u_timer (
    .clk(clk),
    .reset_n(reset_n),
    .ce(ce),
    .tick(ref_rise),
    .cfg(tmr_cfg),
    .start(tmr_start),
    .stop(tmr_stop),
    .ack(tmr_ack),
    .count(tmr_count),
    .wave(tmr_wave),
    .flag(tmr_flag),
    .baud_tick(tmr_tick)
  );

  // whole next state; channel work loops over both channels
  always_comb begin
    s_next = s_reg;
    s_next.ref_sync = {s_reg.ref_sync[1:0], ref_clk};
    if (s_reg.ref_sync[2] == s_reg.ref_sync[1]) begin
      s_next.ref_lvl = s_reg.ref_sync[1];
    end
    if (ref_rise) begin
      s_next.pre = (s_reg.pre == `DUCOM_PRE_LAST) ? 3'h0 : s_reg.pre + 3'h1;
    end
    if (base_tick) begin
      s_next.div = s_reg.div + 7'h01;       // binary chain feeds the /2^k taps
    end
    irq_any = tmr_cfg.irq_en && tmr_flag;
    c = s_reg.ch[0];
    n = c;
    cf = ch_cfg[0];
    word = '0;
    rt = 1'b0;
    tt = 1'b0;
    has_p = 1'b0;
    line_in = 1'b1;
    tx_push = 1'b0;
    tx_pop = 1'b0;
    rx_push = 1'b0;
    rx_take = 1'b0;
    last = 3'h0;
    dmask = 8'h00;
    for (int i = 0; i < 2; i++) begin       // channels share nothing but rates and the irq output [RQ1]
      c = s_reg.ch[i];
      n = c;
      cf = ch_cfg[i];
      rt = rate_tick(cf.rx_rate, base_tick, s_reg.div, tmr_tick); // [RQ11]
      tt = rate_tick(cf.tx_rate, base_tick, s_reg.div, tmr_tick); // [RQ11]
      last = {1'b1, cf.bits_sel};           // index of last data bit [RQ2]
      dmask = 8'hFF >> (~cf.bits_sel);      // [RQ2]
      has_p = cf.par_en || cf.multidrop;
      n.rx_on = cf.rx_en;
      n.tx_on = cf.tx_en;
      n.rts_n = ~cf.rts_on;                 // [RQ12]
      // pin synchronisers: stage one feeds stage two only
      n.rxd_sync = {c.rxd_sync[1:0], rxd[i]};
      if (c.rxd_sync[2] == c.rxd_sync[1]) begin
        n.rxd_lvl = c.rxd_sync[1];
      end
      n.cts_sync = {c.cts_sync[1:0], cts_n[i]};
      if (c.cts_sync[2] == c.cts_sync[1]) begin
        n.cts_lvl = c.cts_sync[1];          // [RQ12]
      end
      line_in = (cf.mode == ducom_pkg::mode_local) ? c.tx_line : c.rxd_lvl; // [RQ7]
      rx_take = rx_pop[i] && (c.rx_cnt != 3'h0);
      tx_push = tx_valid[i] && c.tx_on && (c.tx_cnt != `DUCOM_TX_DEPTH);
      tx_pop = 1'b0;
      rx_push = 1'b0;
      if (tx_push) begin
        n.tx_mem[c.tx_rd ^ c.tx_cnt[0]] = tx_data[i]; // [RQ5]
      end
      if (err_clr[i]) begin
        n.err = 1'b0;                       // cleared first so a new error wins
      end

      // transmitter: start, data lsb first, parity, stop
      unique case (c.tx_st)
        ducom_pkg::tx_idle: begin
          n.tx_line = 1'b1;
          if (c.tx_cnt != 2'h0 && c.tx_on && (!cf.cts_en || !c.cts_lvl) &&
              (cf.mode == ducom_pkg::mode_normal || cf.mode == ducom_pkg::mode_local)) begin
            tx_pop = 1'b1;                  // cts gates the next character [RQ12]
            n.tx_sh = c.tx_mem[c.tx_rd] & dmask;
            n.tx_pbit = cf.multidrop ? cf.tx_addr :
                        ((^(c.tx_mem[c.tx_rd] & dmask)) ^ cf.par_odd); // [RQ3] [RQ8]
            n.tx_st = ducom_pkg::tx_start;
            n.tx_sub = 5'h00;
            n.tx_line = 1'b0;               // start bit low [RQ16]
          end
        end
        ducom_pkg::tx_start, ducom_pkg::tx_data, ducom_pkg::tx_par: begin
          if (tt) begin
            n.tx_sub = {1'b0, c.tx_sub[3:0] + 4'h1};
            if (c.tx_sub[3:0] == `DUCOM_OVS) begin
              if (c.tx_st == ducom_pkg::tx_start ||
                  (c.tx_st == ducom_pkg::tx_data && c.tx_bit != last)) begin
                n.tx_st = ducom_pkg::tx_data;
                n.tx_bit = (c.tx_st == ducom_pkg::tx_start) ? 3'h0 : c.tx_bit + 3'h1;
                n.tx_sh = (c.tx_st == ducom_pkg::tx_start) ? c.tx_sh : {1'b0, c.tx_sh[7:1]};
                n.tx_line = n.tx_sh[0];     // lsb first [RQ16]
              end else if (c.tx_st == ducom_pkg::tx_data && has_p) begin
                n.tx_st = ducom_pkg::tx_par;
                n.tx_line = c.tx_pbit;      // [RQ3]
              end else begin
                n.tx_st = ducom_pkg::tx_stop;
                n.tx_line = 1'b1;           // stop interval high [RQ16]
              end
            end
          end
        end
        ducom_pkg::tx_stop: begin
          if (tt) begin
            n.tx_sub = c.tx_sub + 5'h01;
            if (c.tx_sub == cf.stop16) begin
              n.tx_st = ducom_pkg::tx_idle; // stop16+1 sixteenths [RQ4]
              n.tx_sub = 5'h00;
            end
          end
        end
        default: n.tx_st = ducom_pkg::tx_idle;
      endcase

      // receiver: midpoint start check, then one sample per 16 ticks
      unique case (c.rx_st)
        ducom_pkg::rx_idle: begin
          if (!line_in && c.rx_on && cf.mode != ducom_pkg::mode_remote) begin
            n.rx_st = ducom_pkg::rx_start;
            n.rx_sub = 4'h0;
          end
        end
        ducom_pkg::rx_start: begin
          if (rt) begin
            n.rx_sub = c.rx_sub + 4'h1;
            if (c.rx_sub == `DUCOM_MID) begin
              n.rx_sub = 4'h0;
              n.rx_bit = 3'h0;
              n.rx_par = 1'b0;
              n.rx_st = line_in ? ducom_pkg::rx_idle : ducom_pkg::rx_data; // [RQ17]
            end
          end
        end
        ducom_pkg::rx_data, ducom_pkg::rx_par, ducom_pkg::rx_stop: begin
          if (rt) begin
            n.rx_sub = c.rx_sub + 4'h1;
            if (c.rx_sub == `DUCOM_OVS) begin          // bit centre [RQ17]
              if (c.rx_st == ducom_pkg::rx_data) begin
                n.rx_sh = {line_in, c.rx_sh[7:1]};
                n.rx_par = c.rx_par ^ line_in;
                n.rx_bit = c.rx_bit + 3'h1;
                if (c.rx_bit == last) begin
                  n.rx_st = has_p ? ducom_pkg::rx_par : ducom_pkg::rx_stop;
                end
              end else if (c.rx_st == ducom_pkg::rx_par) begin
                n.rx_pbit = line_in;
                n.rx_st = ducom_pkg::rx_stop;
              end else begin
                rx_push = 1'b1;
                n.rx_st = ducom_pkg::rx_idle;
              end
            end
          end
        end
        default: n.rx_st = ducom_pkg::rx_idle;
      endcase

      // finished character: right-align, flag errors, queue or overrun
      word.data = c.rx_sh >> (~cf.bits_sel);           // [RQ2]
      word.frame_err = !line_in;                        // [RQ6]
      word.par_flag = cf.multidrop ? c.rx_pbit :
                      (cf.par_en && (c.rx_par ^ c.rx_pbit ^ cf.par_odd)); // [RQ3] [RQ8]
      if (rx_push) begin
        if (c.rx_cnt == `DUCOM_RX_DEPTH && !rx_take) begin
          n.err = 1'b1;                     // overrun drops the new character [RQ6]
          rx_push = 1'b0;
        end else begin
          n.rx_mem[c.rx_rd + c.rx_cnt[1:0]] = word; // [RQ5]
          if (word.frame_err || (word.par_flag && !cf.multidrop)) begin
            n.err = 1'b1;                   // [RQ6]
          end
        end
      end
      if (rx_take) begin
        n.rx_rd = c.rx_rd + 2'h1;
      end
      if (tx_pop) begin
        n.tx_rd = ~c.tx_rd;
      end
      n.rx_cnt = c.rx_cnt + {2'h0, rx_push} - {2'h0, rx_take};
      n.tx_cnt = c.tx_cnt + {1'b0, tx_push} - {1'b0, tx_pop};

      // line driver per mode; echo and remote send the received line back
      unique case (cf.mode)
        ducom_pkg::mode_normal: n.txd = c.tx_line;
        ducom_pkg::mode_local: n.txd = 1'b1;
        ducom_pkg::mode_echo, ducom_pkg::mode_remote: n.txd = c.rxd_lvl; // [RQ7]
      endcase
      irq_any = irq_any || (|(cf.irq_mask &
                {c.rx_cnt != 3'h0, c.tx_cnt == 2'h0 && c.tx_st == ducom_pkg::tx_idle,
                 c.err}));                  // each source masked alone [RQ6]
      s_next.ch[i] = n;
    end
    s_next.irq = irq_any;
  end

  // everything idle, disabled and empty after reset [RQ18]
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '{ch: '{CH_RST, CH_RST}, default: '0};
    end else if (ce) begin
      s_reg <= s_next;
    end
  end

  // per-channel output wiring
  for (genvar g = 0; g < 2; g++) begin : g_ch
    assign txd[g] = s_reg.ch[g].txd;
    assign rts_n[g] = s_reg.ch[g].rts_n;
    assign tx_ready[g] = s_reg.ch[g].tx_on && (s_reg.ch[g].tx_cnt != `DUCOM_TX_DEPTH);
    assign rx_valid[g] = (s_reg.ch[g].rx_cnt != 3'h0);
    assign rx_word[g] = s_reg.ch[g].rx_mem[s_reg.ch[g].rx_rd];
    assign ch_err[g] = s_reg.ch[g].err;
  end
  assign irq = s_reg.irq;
endmodule : ducom_top
`default_nettype wire

// [testbench/ducom_chk.sv]
// Purpose: port-level assertions for the dual serial unit
// Assumes: one clock domain; ce low only freezes state
// Notes: bound to ducom_top from the bench top file
`timescale 1ns/1ps
`default_nettype none
module ducom_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [1:0] txd,
  input wire logic [1:0] rts_n,
  input wire ducom_pkg::ducom_cfg_t [1:0] ch_cfg,
  input wire logic [1:0] tx_ready,
  input wire ducom_pkg::ducom_rx_t [1:0] rx_word,
  input wire logic [1:0] rx_valid,
  input wire logic [1:0] rx_pop,
  input wire logic [1:0] err_clr,
  input wire logic [1:0] ch_err,
  input wire ducom_pkg::ducom_tmr_cfg_t tmr_cfg,
  input wire logic tmr_ack,
  input wire logic tmr_flag,
  input wire logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  // two steps: disabled for two edges means tx_on has followed
  sequence s_tx_off;
    !ch_cfg[1].tx_en ##1 !ch_cfg[1].tx_en;
  endsequence
  sequence s_run;
    reset_n ##1 1'b1;
  endsequence
  property p_rst;
    $rose(reset_n) |-> txd == 2'h3 && rts_n == 2'h3 && tx_ready == 2'h0 && rx_valid == 2'h0
      && ch_err == 2'h0 && !tmr_flag && !irq;
  endproperty
  property p_txr_dis;
    s_tx_off |-> !tx_ready[1];
  endproperty
  // past needs a live prior edge, else it sees the reset-time config
  property p_rts;
    s_run |-> rts_n[0] != $past(ch_cfg[0].rts_on);
  endproperty
  property p_start_low;
    $fell(txd[0]) |-> !txd[0] [*8];
  endproperty
  property p_err_irq;
    ch_err[0] && ch_cfg[0].irq_mask[0] |=> irq;
  endproperty
  property p_tmr_irq;
    tmr_flag && tmr_cfg.irq_en |=> irq;
  endproperty
  property p_flag_hold;
    tmr_flag && !tmr_ack |=> tmr_flag;
  endproperty
  property p_err_hold;
    ch_err[0] && !err_clr[0] |=> ch_err[0];
  endproperty
  property p_rxv_hold;
    rx_valid[1] && !rx_pop[1] |=> rx_valid[1] && $stable(rx_word[1]);
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not quiet after reset");
  a_txr_dis: assert property (p_txr_dis) else $error("tx ready while disabled");
  a_rts: assert property (p_rts) else $error("rts_n not following config");
  a_start_low: assert property (p_start_low) else $error("short low on txd");
  a_err_irq: assert property (p_err_irq) else $error("error irq missing");
  a_tmr_irq: assert property (p_tmr_irq) else $error("timer irq missing");
  a_flag_hold: assert property (p_flag_hold) else $error("timer flag lost");
  a_err_hold: assert property (p_err_hold) else $error("error flag lost");
  a_rxv_hold: assert property (p_rxv_hold) else $error("rx head not held");
endmodule : ducom_chk
`default_nettype wire

// [testbench/ducom_peer.sv]
// Purpose: remote serial station: sends on both lines, receives on line 0 only
// Assumes: bit time of 32 reference periods (timer reload every 2)
// Notes: time based, so it is as unsynchronised as a real terminal
`timescale 1ns/1ps
`default_nettype none
module ducom_peer #(
  parameter realtime BIT = 8680.5
) (
  input wire logic [1:0] txd,
  output logic [1:0] rxd
);
  initial rxd = 2'h3; // idle high
  // one frame: start, n bits lsb first, parity, one stop
  task automatic send(input int ch, input logic [7:0] d, input int n, input logic odd,
    input logic flip);
    logic p;
    p = (^(d & 8'((1 << n) - 1))) ^ odd ^ flip; // flip forces a parity fault
    rxd[ch] = 1'b0;
    #BIT;
    for (int i = 0; i < n; i++) begin
      rxd[ch] = d[i];
      #BIT;
    end
    rxd[ch] = p;
    #BIT;
    rxd[ch] = 1'b1;
    #BIT;
  endtask : send
  // receive an 8-bit frame with parity on channel 0, sampled mid-bit
  task automatic take(output logic [7:0] d, output logic p, output logic stp);
    @(negedge txd[0]);
    #(BIT / 2);
    for (int i = 0; i < 8; i++) begin
      #BIT;
      d[i] = txd[0];
    end
    #BIT;
    p = txd[0];
    #BIT;
    stp = txd[0];
  endtask : take
endmodule : ducom_peer
`default_nettype wire

// [testbench/ducom_top_bench.sv]
// Purpose: self-checking bench for the dual serial unit
// Assumes: ce high but for one freeze test; timer mode is the rate source
// Notes: timer rate source keeps frames short enough for one run
`timescale 1ns/1ps
`default_nettype none
module ducom_top_bench;
  logic clk, reset_n, ce, ref_clk, tmr_start, tmr_stop, tmr_ack, tmr_wave, tmr_flag, irq;
  logic [1:0] rxd, txd, cts_n, rts_n, tx_valid, tx_ready, rx_valid, rx_pop, err_clr, ch_err;
  logic [1:0][7:0] tx_data;
  logic [15:0] tmr_count, cnt;
  ducom_pkg::ducom_cfg_t [1:0] ch_cfg;
  ducom_pkg::ducom_rx_t [1:0] rx_word;
  ducom_pkg::ducom_tmr_cfg_t tmr_cfg;
  logic [7:0] d;
  logic p, s;
  int n_fail, checks, cyc, cyc_all;
  localparam logic [7:0] tx_vals [2] = '{8'h5B, 8'hC3};
  localparam logic [7:0] rx_vals [5] = '{8'h2A, 8'h55, 8'h01, 8'h7F, 8'h40};
  ducom_top i_dut (.clk(clk), .reset_n(reset_n), .ce(ce), .ref_clk(ref_clk), .rxd(rxd),
    .txd(txd), .cts_n(cts_n), .rts_n(rts_n), .ch_cfg(ch_cfg), .tx_data(tx_data),
    .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
    .rx_pop(rx_pop), .err_clr(err_clr), .ch_err(ch_err), .tmr_cfg(tmr_cfg),
    .tmr_start(tmr_start), .tmr_stop(tmr_stop), .tmr_ack(tmr_ack), .tmr_count(tmr_count),
    .tmr_wave(tmr_wave), .tmr_flag(tmr_flag), .irq(irq));
  ducom_peer i_peer (.txd(txd), .rxd(rxd));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // 3.6864 MHz rate reference, free running and unrelated to clk
  initial begin
    ref_clk = 1'b0;
    forever #135.634 ref_clk = ~ref_clk;
  end
  task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
    checks++;
    if (got !== exp) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task results;
    if (n_fail == 0 && checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : results
  // one char into channel 0; valid held until ready seen, then an idle cycle
  task automatic put(input logic [7:0] v);
    tx_data[0] = v;
    tx_valid[0] = 1'b1;
    for (int i = 0; i < 50 && tx_ready[0] !== 1'b1; i++) @(negedge clk);
    @(negedge clk);
    tx_valid[0] = 1'b0;
    @(negedge clk);
  endtask : put
  task automatic pulse_pop(input int ch);
    rx_pop[ch] = 1'b1;
    @(negedge clk);
    rx_pop[ch] = 1'b0;
    @(negedge clk);
  endtask : pulse_pop
  // cycle ceiling well above the ~75k cycles the frames need
  always @(posedge clk) begin
    cyc_all++;
    if (cyc_all == 90000) begin
      n_fail++;
      results();
    end
  end
  initial begin
    reset_n = 1'b0;
    ce = 1'b1;
    cts_n = 2'h3;
    tx_data = '0;
    tx_valid = 2'h0;
    rx_pop = 2'h0;
    err_clr = 2'h0;
    {tmr_start, tmr_stop, tmr_ack} = 3'h0;
    ch_cfg[0] = '{rx_en: 1'b1, tx_en: 1'b1, bits_sel: 2'h3, par_en: 1'b1, par_odd: 1'b0,
      stop16: 5'h0F, mode: ducom_pkg::mode_normal, multidrop: 1'b0, tx_addr: 1'b0,
      rx_rate: 4'h8, tx_rate: 4'h8, cts_en: 1'b1, rts_on: 1'b1, irq_mask: 3'h1};
    ch_cfg[1] = '{rx_en: 1'b1, tx_en: 1'b0, bits_sel: 2'h2, par_en: 1'b1, par_odd: 1'b1,
      stop16: 5'h0F, mode: ducom_pkg::mode_normal, multidrop: 1'b0, tx_addr: 1'b0,
      rx_rate: 4'h8, tx_rate: 4'h8, cts_en: 1'b0, rts_on: 1'b0, irq_mask: 3'h0};
    tmr_cfg = '{timer_mode: 1'b0, irq_en: 1'b0, preload: 16'h0005, duty: 16'h0000};
    repeat (16) @(negedge clk);
    chk("reset_out", 16'h1E00, 16'({txd, rts_n, tx_ready, rx_valid, ch_err, irq, tmr_flag,
      tmr_wave}));
    chk("reset_cnt", 16'h0000, tmr_count);
    reset_n = 1'b1;
    // counter mode: count loads at start, flag after preload+1 reference edges
    tmr_start = 1'b1;
    @(negedge clk);
    tmr_start = 1'b0;
    chk("tmr_count", 16'h0005, tmr_count);
    for (cyc = 0; cyc < 400 && tmr_flag !== 1'b1; cyc++) @(negedge clk);
    chk("flag_time", 16'h0001, 16'(cyc >= 135 && cyc <= 172));
    tmr_ack = 1'b1;
    @(negedge clk);
    tmr_ack = 1'b0;
    chk("flag_ack", 16'h0000, 16'(tmr_flag));
    // ce low freezes the running counter
    ce = 1'b0;
    cnt = tmr_count;
    repeat (100) @(negedge clk);
    chk("ce_hold", cnt, tmr_count);
    ce = 1'b1;
    tmr_stop = 1'b1;
    @(negedge clk);
    tmr_stop = 1'b0;
    cnt = tmr_count;
    repeat (100) @(negedge clk);
    chk("tmr_stop", cnt, tmr_count);
    // timer mode, reload every two edges: periodic irq and baud source
    tmr_cfg = '{timer_mode: 1'b1, irq_en: 1'b1, preload: 16'h0001, duty: 16'h0001};
    tmr_start = 1'b1;
    @(negedge clk);
    tmr_start = 1'b0;
    for (cyc = 0; cyc < 200 && irq !== 1'b1; cyc++) @(negedge clk);
    chk("tmr_irq", 16'h0001, 16'(irq));
    // square wave: high only while the count sits below duty
    for (cyc = 0; cyc < 100 && tmr_wave !== 1'b1; cyc++) @(negedge clk);
    chk("wave_hi", 16'h0001, 16'(tmr_wave));
    for (cyc = 0; cyc < 100 && tmr_wave !== 1'b0; cyc++) @(negedge clk);
    chk("wave_lo", 16'h0000, 16'(tmr_wave));
    tmr_cfg.irq_en = 1'b0;
    chk("rts_n", 16'h0002, 16'(rts_n));
    chk("tx1_ready", 16'h0000, 16'(tx_ready[1]));
    // cts blocks the transmitter, so two chars fill the fifo
    put(tx_vals[0]);
    put(tx_vals[1]);
    chk("tx_full", 16'h0000, 16'(tx_ready[0]));
    repeat (200) @(negedge clk);
    chk("txd_held", 16'h0001, 16'(txd[0]));
    cts_n = 2'h2;
    fork
      for (int i = 0; i < 2; i++) begin
        i_peer.take(d, p, s);
        chk("peer_data", 16'(tx_vals[i]), 16'(d));
        chk("peer_par", 16'(^tx_vals[i]), 16'(p));
        chk("peer_stop", 16'h0001, 16'(s));
      end
      for (int i = 0; i < 5; i++) i_peer.send(1, rx_vals[i], 7, 1'b1, 1'b0);
    join
    @(negedge clk);
    // fifth char meets a full receive fifo and is dropped
    chk("ovr_err", 16'h0001, 16'(ch_err[1]));
    for (int i = 0; i < 4; i++) begin
      chk("rx1_word", 16'({2'b00, rx_vals[i]}), 16'(rx_word[1]));
      pulse_pop(1);
    end
    chk("rx1_empty", 16'h0000, 16'(rx_valid[1]));
    i_peer.send(0, 8'hA7, 8, 1'b0, 1'b1);
    @(negedge clk);
    chk("par_err", 16'h0001, 16'(ch_err[0]));
    chk("rx0_word", 16'h01A7, 16'(rx_word[0]));
    chk("err_irq", 16'h0001, 16'(irq));
    ch_cfg[0].irq_mask = 3'h0;
    repeat (2) @(negedge clk);
    chk("irq_masked", 16'h0000, 16'(irq));
    ch_cfg[0].irq_mask = 3'h1;
    err_clr[0] = 1'b1;
    @(negedge clk);
    err_clr[0] = 1'b0;
    repeat (2) @(negedge clk);
    chk("err_clr", 16'h0000, 16'({ch_err[0], irq}));
    pulse_pop(0);
    // multidrop: ninth bit kept as address mark, no parity error
    ch_cfg[0].multidrop = 1'b1;
    i_peer.send(0, 8'h81, 8, 1'b1, 1'b0);
    @(negedge clk);
    chk("mdrop", 16'h0181, 16'({ch_err[0], rx_word[0]}));
    pulse_pop(0);
    // local loop, still multidrop: txd stays high, receiver hears transmitter
    ch_cfg[0].mode = ducom_pkg::mode_local;
    put(8'h3C);
    repeat (1200) @(negedge clk);
    chk("loop_txd", 16'h0001, 16'(txd[0]));
    for (cyc = 0; cyc < 12000 && rx_valid[0] !== 1'b1; cyc++) @(negedge clk);
    chk("loop_word", 16'h003C, 16'({ch_err[0], rx_word[0]}));
    results();
  end
endmodule : ducom_top_bench
bind ducom_top ducom_chk i_chk (.clk(clk), .reset_n(reset_n), .txd(txd), .rts_n(rts_n),
  .ch_cfg(ch_cfg), .tx_ready(tx_ready), .rx_word(rx_word), .rx_valid(rx_valid),
  .rx_pop(rx_pop), .err_clr(err_clr), .ch_err(ch_err), .tmr_cfg(tmr_cfg),
  .tmr_ack(tmr_ack), .tmr_flag(tmr_flag), .irq(irq));
`default_nettype wire
